// >>> src/ipm_masker.sv
// Interrupt priority masker: level filter for 40 sources, mask pseudo stack,
// APB register slave with zero wait states.
// Assumes sources and the acceptance strobe come from logic on pclk.
`timescale 1ns/1ns

// Overview of operation
// - Enable clear: sources pass straight to the CPU, stack untouched.
// - Enable set: every source passes through the priority masking logic.
// - Enabled: a source reaches the CPU only if its level >= mask.
// - Status bits 6 and 2 read zero and ignore writes.
// - Status bit 5 shows an empty stack, updated on every push and pull.
// - Status bit 4 shows all four slots used, updated on every push and pull.
// - Pushing while full discards the oldest entry in slot 0.
// - Writing 1 to status bit 3 while enabled pulls the newest entry into the mask.
// - A pull shifts the stack toward slot 3 and zero fills slot 0.
// - Software mask writes change the mask except when a push or pull acts in the same cycle, and never push.
// - Pull plus mask write while enabled: pulled value wins.
// - Interrupt taken while enabled pushes the current mask; with a pull in the same cycle neither acts and the mask holds.
// - Stack register holds slots 3..0 at bits 7:6, 5:4, 3:2, 1:0.
// - Ten level registers hold 2-bit levels for groups of four sources.
// - Level register n bits 7:6..1:0 serve sources n*4+3..n*4+0.
// - Status register at index 3E resets to 20h.
// - Level registers at indices 3050..3059 reset to 00h.
module ipm_masker
    import ipm_pkg::*;
(
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [IPM_ADDR_W-1:0]   paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire logic [IPM_NUM_SRC-1:0]  irq_src,
    input  wire logic                    irq_ack,
    input  wire logic [5:0]              irq_ack_id,
    output logic      [IPM_NUM_SRC-1:0]  irq_cpu
);

    ////////////////////////////////////////////////////////////////////////////
    // State.

    ipm_ctrl_t                          ctrl_q;
    ipm_ctrl_t                          ctrl_d;
    ipm_stack_t                         stack_q;
    ipm_stack_t                         stack_d;
    logic [2:0]                         cnt_q;
    logic [2:0]                         cnt_d;
    logic [IPM_NUM_LVL_REGS-1:0][7:0]   lvl_q;
    logic [IPM_NUM_LVL_REGS-1:0][7:0]   lvl_d;
    logic [31:0]                        rdata_q;
    logic [31:0]                        rdata_d;
    logic                               err_q;
    logic                               err_d;
    logic [IPM_NUM_SRC-1:0]             irq_cpu_q;
    logic [IPM_NUM_SRC-1:0]             irq_cpu_d;

    ////////////////////////////////////////////////////////////////////////////
    // Address decode.

    logic [IPM_IDX_W-1:0]   idx;
    logic                   aligned;
    logic                   hit_sc;
    logic                   hit_stack;
    logic                   hit_lvl;
    logic [IPM_IDX_W-1:0]   lvl_off;
    logic [3:0]             lvl_sel;
    logic                   mapped;
    logic                   wr_access;

    always_comb begin
        idx       = paddr[IPM_ADDR_W-1:2];
        aligned   = (paddr[1:0] == 2'h0);
        hit_sc    = aligned && (idx == IPM_IDX_SC);
        hit_stack = aligned && (idx == IPM_IDX_STACK);
        hit_lvl   = aligned && (idx >= IPM_IDX_LVL0) && (idx <= IPM_IDX_LVL_LAST);
        lvl_off   = idx - IPM_IDX_LVL0;
        lvl_sel   = lvl_off[3:0];
        mapped    = hit_sc || hit_stack || hit_lvl;
        wr_access = psel && penable && pwrite && mapped;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status word as read back.

    logic [7:0] sc_view;

    always_comb begin
        sc_view                   = 8'h00;
        sc_view[IPM_SC_EN_BIT]    = ctrl_q.en;
        sc_view[IPM_SC_EMPTY_BIT] = (cnt_q == 3'h0);
        sc_view[IPM_SC_FULL_BIT]  = (cnt_q == IPM_CNT_FULL);
        sc_view[IPM_SC_MASK_LSB +: 2] = ctrl_q.mask;
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB read data and error, captured in the setup cycle.

    always_comb begin
        rdata_d = rdata_q;
        err_d   = err_q;
        if (psel && !penable) begin
            rdata_d = 32'h0000_0000;
            err_d   = !mapped;
            if (hit_sc) begin
                rdata_d[7:0] = sc_view;
            end else if (hit_stack) begin
                rdata_d[7:0] = stack_q;
            end else if (hit_lvl) begin
                rdata_d[7:0] = lvl_q[lvl_sel];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= 32'h0000_0000;
            err_q   <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            err_q   <= err_d;
        end
    end

    always_comb begin
        pready  = 1'b1;
        prdata  = rdata_q;
        pslverr = psel && penable && err_q;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Level registers.

    always_comb begin
        lvl_d = lvl_q;
        if (wr_access && hit_lvl) begin
            lvl_d[lvl_sel] = pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int n = 0; n < IPM_NUM_LVL_REGS; n++) begin
                lvl_q[n] <= IPM_LVL_RESET;
            end
        end else begin
            lvl_q <= lvl_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Acceptance decode and level lookup.

    ipm_ack_t                           ack;
    logic [2*IPM_NUM_SRC-1:0]           lvl_flat;
    logic [1:0]                         ack_level;
    logic [1:0]                         raised_mask;
    logic                               do_push;
    logic                               do_pull;
    logic                               sc_write;

    always_comb begin
        ack.valid   = irq_ack && (irq_ack_id < 6'(IPM_NUM_SRC));
        ack.id      = irq_ack_id;
        lvl_flat    = lvl_q;
        ack_level   = 2'h0;
        if (ack.valid) begin
            ack_level = lvl_flat[{ack.id, 1'b0} +: 2];
        end
        raised_mask = (ack_level == IPM_MASK_MAX) ? IPM_MASK_MAX
                                                  : ack_level + 2'h1;
        sc_write    = wr_access && hit_sc;
        do_push     = ctrl_q.en && ack.valid;
        do_pull     = ctrl_q.en && sc_write && pwdata[IPM_SC_PULL_BIT];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control and pseudo stack.

    always_comb begin
        ctrl_d  = ctrl_q;
        stack_d = stack_q;
        cnt_d   = cnt_q;
        if (sc_write) begin
            ctrl_d.en   = pwdata[IPM_SC_EN_BIT];
            ctrl_d.mask = pwdata[IPM_SC_MASK_LSB +: 2];
        end
        if (do_push && do_pull) begin
            ctrl_d.mask = ctrl_q.mask;
        end else if (do_push) begin
            stack_d = {ctrl_q.mask, stack_q.slot3, stack_q.slot2,
                       stack_q.slot1};
            if (cnt_q != IPM_CNT_FULL) begin
                cnt_d = cnt_q + 3'h1;
            end
            ctrl_d.mask = raised_mask;
        end else if (do_pull) begin
            ctrl_d.mask = stack_q.slot3;
            stack_d     = {stack_q.slot2, stack_q.slot1, stack_q.slot0,
                           2'h0};
            if (cnt_q != 3'h0) begin
                cnt_d = cnt_q - 3'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q.en   <= IPM_SC_RESET[IPM_SC_EN_BIT];
            ctrl_q.mask <= IPM_SC_RESET[1:0];
            stack_q     <= IPM_STACK_RESET;
            cnt_q       <= 3'h0;
        end else begin
            ctrl_q  <= ctrl_d;
            stack_q <= stack_d;
            cnt_q   <= cnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Request filter toward the CPU.

    always_comb begin
        irq_cpu_d = '0;
        for (int i = 0; i < IPM_NUM_SRC; i++) begin
            if (!ctrl_q.en) begin
                irq_cpu_d[i] = irq_src[i];
            end else begin
                irq_cpu_d[i] = irq_src[i] &&
                               (lvl_flat[2*i +: 2] >= ctrl_q.mask);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_cpu_q <= '0;
        end else begin
            irq_cpu_q <= irq_cpu_d;
        end
    end

    always_comb begin
        irq_cpu = irq_cpu_q;
    end

endmodule

// >>> src/ipm_pkg.sv
// Package of the interrupt priority masker: register indices, field positions,
// reset values and the packed carriers shared by the design.
// Assumes a 32-bit APB with 16-bit byte addresses; byte address = 4 * index.
package ipm_pkg;

    localparam int          IPM_NUM_SRC       = 40;
    localparam int          IPM_NUM_LVL_REGS  = 10;
    localparam int          IPM_SRC_PER_REG   = 4;
    localparam int          IPM_STACK_DEPTH   = 4;
    localparam int          IPM_ADDR_W        = 16;
    localparam int          IPM_IDX_W         = 14;

    localparam logic [13:0] IPM_IDX_SC        = 14'h003E;
    localparam logic [13:0] IPM_IDX_STACK     = 14'h003F;
    localparam logic [13:0] IPM_IDX_LVL0      = 14'h3050;
    localparam logic [13:0] IPM_IDX_LVL_LAST  = 14'h3059;

    localparam int          IPM_SC_EN_BIT     = 7;
    localparam int          IPM_SC_RSVD6_BIT  = 6;
    localparam int          IPM_SC_EMPTY_BIT  = 5;
    localparam int          IPM_SC_FULL_BIT   = 4;
    localparam int          IPM_SC_PULL_BIT   = 3;
    localparam int          IPM_SC_RSVD2_BIT  = 2;
    localparam int          IPM_SC_MASK_LSB   = 0;

    localparam logic [7:0]  IPM_SC_RESET      = 8'h20;
    localparam logic [7:0]  IPM_STACK_RESET   = 8'h00;
    localparam logic [7:0]  IPM_LVL_RESET     = 8'h00;
    localparam logic [1:0]  IPM_MASK_MAX      = 2'h3;
    localparam logic [2:0]  IPM_CNT_FULL      = 3'h4;

    typedef struct packed {
        logic       en;
        logic [1:0] mask;
    } ipm_ctrl_t;

    typedef struct packed {
        logic [1:0] slot3;
        logic [1:0] slot2;
        logic [1:0] slot1;
        logic [1:0] slot0;
    } ipm_stack_t;

    typedef struct packed {
        logic       valid;
        logic [5:0] id;
    } ipm_ack_t;

endpackage

// >>> verification/ipm_cpu_model.sv
// CPU side model: accepts a presented request with a one-cycle pulse.
// Assumes the bench asks for one acceptance at a time.
`timescale 1ns/1ns
module ipm_cpu_model
    import ipm_pkg::*;
(
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic [IPM_NUM_SRC-1:0] irq_cpu,
    input  wire logic                   take,
    input  wire logic [5:0]             take_id,
    output logic                        irq_ack,
    output logic [5:0]                  irq_ack_id
);
    // Only a request that is presented can be accepted; idle id keeps changing.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_ack    <= 1'b0;
            irq_ack_id <= 6'h00;
        end else begin
            irq_ack    <= take && irq_cpu[take_id];
            irq_ack_id <= take ? take_id : ~irq_ack_id;
        end
    end
endmodule

// >>> verification/ipm_masker_props.sv
// Checker of the masker's APB and request ports.
// Assumes it is bound to ipm_masker and sees only its ports.
`timescale 1ns/1ns
module ipm_props
    import ipm_pkg::*;
(
    input wire logic                   pclk,
    input wire logic                   presetn,
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [IPM_ADDR_W-1:0]  paddr,
    input wire logic [31:0]            pwdata,
    input wire logic [31:0]            prdata,
    input wire logic                   pready,
    input wire logic                   pslverr,
    input wire logic [IPM_NUM_SRC-1:0] irq_src,
    input wire logic [IPM_NUM_SRC-1:0] irq_cpu
);
    logic en_q;
    wire  acc = psel && penable;
    // Shadow of the enable bit, taken from completed status writes.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) en_q <= 1'b0;
        else if (acc && pwrite && paddr == 16'h00F8) en_q <= pwdata[7];
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_rd; acc && !pwrite; endsequence
    sequence s_sc_rd; s_rd ##0 paddr == 16'h00F8; endsequence
    property p_rdy; acc |-> pready; endproperty
    property p_err; pslverr |-> acc; endproperty
    property p_unal; s_rd ##0 paddr[1:0] != 2'h0 |-> pslverr && prdata == 32'h0; endproperty
    property p_map; acc && (paddr == 16'h00F8 || paddr == 16'h00FC) |-> !pslverr; endproperty
    property p_rsvd; s_sc_rd |-> !prdata[6] && !prdata[3] && !prdata[2]; endproperty
    property p_flag; s_sc_rd |-> !(prdata[5] && prdata[4]); endproperty
    property p_hi; s_rd |-> prdata[31:8] == 24'h0; endproperty
    property p_byp; $past(presetn) && !$past(en_q) |-> irq_cpu == $past(irq_src); endproperty
    property p_filt; $past(presetn) && $past(en_q) |-> (irq_cpu & ~$past(irq_src)) == '0; endproperty
    a_rdy: assert property (p_rdy) else $error("pready low in access");
    a_err: assert property (p_err) else $error("pslverr outside access");
    a_unal: assert property (p_unal) else $error("unaligned read not refused");
    a_map: assert property (p_map) else $error("mapped access refused");
    a_rsvd: assert property (p_rsvd) else $error("reserved status bit set");
    a_flag: assert property (p_flag) else $error("empty and full together");
    a_hi: assert property (p_hi) else $error("upper read data not zero");
    a_byp: assert property (p_byp) else $error("bypass output differs");
    a_filt: assert property (p_filt) else $error("request without source");
endmodule
bind ipm_masker ipm_props i_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .irq_src, .irq_cpu);

// >>> verification/ipm_masker_tb.sv
// Testbench of the masker: APB master, source driver, CPU model, read scoreboard.
// Assumes the status register at 0xF8, the stack at 0xFC, levels from 0xC140.
`timescale 1ns/1ns
module ipm_masker_tb
    import ipm_pkg::*;
();
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_ack, take, en;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, er;
    logic [39:0] irq_src, irq_cpu, ev;
    logic [5:0]  irq_ack_id, take_id;
    logic [7:0]  lv [10];
    logic [7:0]  stk;
    logic [1:0]  msk;
    logic [31:0] rd_q [$];
    logic [5:0]  take_id_tab [6] = '{6'd0, 6'd0, 6'd3, 6'd3, 6'd3, 6'd3};
    int          errors, checks, cnt, seed, cyc;
    ipm_masker i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .irq_src, .irq_ack, .irq_ack_id, .irq_cpu);
    ipm_cpu_model i_cpu (.pclk, .presetn, .irq_cpu, .take, .take_id, .irq_ack, .irq_ack_id);
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    task automatic results();
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            results();
        end
        if (psel && penable && pready && !pwrite) begin
            er = rd_q.pop_front();
            checks++;
            if (prdata !== er) begin
                errors++;
                $display("Error prdata expected %h seen %h", er, prdata);
            end
        end
    end
    task automatic apb(input logic wr, input logic [15:0] a, input logic [7:0] d,
                       input logic [7:0] e);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        if (!wr) rd_q.push_back({24'h0, e});
        @(posedge pclk) penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic chk(input logic [39:0] e);
        repeat (2) @(posedge pclk);
        checks++;
        if (irq_cpu !== e) begin
            errors++;
            $display("Error irq_cpu expected %h seen %h", e, irq_cpu);
        end
    endtask
    function automatic logic [1:0] lvl(input int k);
        return lv[k/4][2*(k%4) +: 2];
    endfunction
    function automatic logic [39:0] filt(input logic [39:0] s);
        for (int k = 0; k < 40; k++) filt[k] = s[k] && lvl(k) >= msk;
    endfunction
    task automatic ack(input logic [5:0] id);
        take <= 1'b1;
        take_id <= id;
        @(posedge pclk) take <= 1'b0;
        if (en && lvl(id) >= msk) begin
            stk = {msk, stk[7:2]};
            msk = (lvl(id) == IPM_MASK_MAX) ? IPM_MASK_MAX : lvl(id) + 2'h1;
            cnt = (cnt < 4) ? cnt + 1 : 4;
        end
        repeat (3) @(posedge pclk);
    endtask
    task automatic rdst();
        apb(1'b0, 16'h00F8, 8'h00, {en, 1'b0, cnt == 0, cnt == 4, 2'h0, msk});
        apb(1'b0, 16'h00FC, 8'h00, stk);
    endtask
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, irq_src, take, take_id} = '0;
        {stk, msk, cnt, en} = '0;
        seed = 32'hAE6D;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, 16'h00F8, 8'h00, IPM_SC_RESET);
        for (int n = 0; n < 10; n++) begin
            apb(1'b0, 16'hC140 + 16'(4*n), 8'h00, IPM_LVL_RESET);
            lv[n] = 8'($random(seed));
            apb(1'b1, 16'hC140 + 16'(4*n), lv[n], 8'h00);
            apb(1'b0, 16'hC140 + 16'(4*n), 8'h00, lv[n]);
        end
        apb(1'b0, 16'hC168, 8'h00, 8'h00);
        apb(1'b0, 16'h00FA, 8'h00, 8'h00);
        apb(1'b1, 16'h00FC, 8'hFF, 8'h00);
        apb(1'b1, 16'h00F8, 8'h4C, 8'h00);
        rdst();
        for (int i = 0; i < 4; i++) begin
            ev = 40'({$random(seed), $random(seed)});
            irq_src <= ev;
            chk(ev);
        end
        irq_src <= '1;
        ack(6'd5);
        rdst();
        en = 1'b1;
        for (int m = 0; m < 4; m++) begin
            msk = 2'(m);
            apb(1'b1, 16'h00F8, {6'h20, msk}, 8'h00);
            chk(filt('1));
        end
        ev = 40'({$random(seed), $random(seed)});
        irq_src <= ev;
        chk(filt(ev));
        irq_src <= '1;
        lv[0] = 8'hE4;
        msk = 2'h0;
        apb(1'b1, 16'hC140, lv[0], 8'h00);
        apb(1'b1, 16'h00F8, 8'h80, 8'h00);
        foreach (take_id_tab[i]) begin
            ack(take_id_tab[i]);
            rdst();
        end
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, 16'h00F8, 8'h8A, 8'h00);
            msk = stk[7:6];
            stk = {stk[5:0], 2'h0};
            cnt = (cnt > 0) ? cnt - 1 : 0;
            rdst();
        end
        results();
    end
endmodule
